/* logic/srpbm_top.v */
// Shared reset pad boot mux: sequences boot steps over one pad that is
// otherwise an active-high reset, plus flash access with reset disabled.
// Assumes pad levels are asynchronous; serial engines live elsewhere.
//
// Function
// - UART boot drives transmit onto shared pad
// - Step four drives shared pad as UART transmit, probes receive pad
// - Pad returns to reset after boot
// - High pad in reset mode holds reset
// - Permanent transmit mode ignores pad level
// - Reset via re-enable command or GPIO source
// - No pad reset while pad is flash out
// - Flash: disable, select, access, re-enable
// - Pad reset is active high
// - Serial step suspends pad reset detection
// - Steps tried one to six, UART fourth
`timescale 1ns/1ns
`include "srpbm_defines.vh"

module srpbm_top
(
    input  wire clk_in,
    input  wire rst_n_in,
    input  wire shared_reset_pad_in,
    input  wire boot_uart_rx_pad_in,
    input  wire gpio_por_pad_in,
    input  wire gpio_por_enable_in,
    input  wire gpio_por_polarity_in,
    input  wire step_done_in,
    input  wire boot_found_in,
    input  wire keep_uart_tx_in,
    input  wire uart_tx_data_in,
    input  wire spi_do_data_in,
    input  wire flash_req_in,
    input  wire flash_done_in,
    input  wire reset_reenable_in,
    output reg  shared_reset_pad_out,
    output reg  shared_reset_pad_oe_out,
    output reg  [2:0] boot_step_out,
    output reg  uart_probe_out,
    output reg  flash_grant_out,
    output reg  hard_reset_disable_flag_out,
    output reg  hard_reset_out,
    output reg  por_reset_out,
    output reg  boot_done_out
);

    // ----------------------------------------
    // Input synchronisers (three flops, last two agree)
    // ----------------------------------------
    reg [2:0] sync_rst;
    reg [2:0] sync_rx;
    reg [2:0] sync_gpio;
    reg       pad_level;
    reg       rx_level;
    reg       gpio_level;

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            sync_rst   <= 3'h0;
            sync_rx    <= 3'h7;
            sync_gpio  <= 3'h0;
            pad_level  <= 1'b0;
            rx_level   <= 1'b1;
            gpio_level <= 1'b0;
        end
        else
        begin
            sync_rx   <= {sync_rx[1:0], boot_uart_rx_pad_in};
            sync_gpio <= {sync_gpio[1:0], gpio_por_pad_in};
            // Our own drive would echo back as a reset request after release,
            // so the reset filter is flushed while we drive the pad
            if (shared_reset_pad_oe_out)
            begin
                sync_rst  <= 3'h0;
                pad_level <= 1'b0;
            end
            else
            begin
                sync_rst <= {sync_rst[1:0], shared_reset_pad_in};
                if (sync_rst[1] == sync_rst[2])
                    pad_level <= sync_rst[2];
            end
            if (sync_rx[1] == sync_rx[2])
                rx_level <= sync_rx[2];
            if (sync_gpio[1] == sync_gpio[2])
                gpio_level <= sync_gpio[2];
        end
    end

    // ----------------------------------------
    // Step table
    // ----------------------------------------
    reg  [`SRPBM_STEP_W-1:0] step;
    wire [`SRPBM_FN_W-1:0]   step_fn;

    srpbm_step_mem i_srpbm_step_mem
    (
        .clk_in  (clk_in),
        .addr_in (step),
        .fn_out  (step_fn)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    reg [`SRPBM_ST_W-1:0] state;
    reg [`SRPBM_FN_W-1:0] pad_fn;
    reg [3:0]             settle;
    reg [15:0]            tmo;
    reg                   dis_flag;

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state    <= `SRPBM_ST_PORWAIT;
            step     <= `SRPBM_STEP_SPI_MST;
            pad_fn   <= `SRPBM_FN_RESET;
            settle   <= 4'h0;
            tmo      <= 16'h0000;
            dis_flag <= 1'b0;
        end
        else
        begin
            case (state)
                `SRPBM_ST_PORWAIT:
                begin
                    // Let the step table read settle before first handover
                    settle <= settle + 4'h1;
                    if (settle == `SRPBM_SETTLE_CYC)
                    begin
                        settle <= 4'h0;
                        state  <= `SRPBM_ST_STEP;
                        pad_fn <= step_fn;
                    end
                end
                `SRPBM_ST_STEP:
                begin
                    tmo <= tmo + 16'h0001;
                    if (boot_found_in)
                    begin
                        pad_fn <= `SRPBM_FN_RESET;
                        state  <= `SRPBM_ST_RUN;
                    end
                    else if (step_done_in || tmo == `SRPBM_STEP_TMO)
                    begin
                        tmo    <= 16'h0000;
                        pad_fn <= `SRPBM_FN_RESET;
                        state  <= `SRPBM_ST_GAP;
                        if (step == `SRPBM_STEP_LAST)
                            step <= `SRPBM_STEP_SPI_MST;
                        else
                            step <= step + 3'h1;
                    end
                end
                `SRPBM_ST_GAP:
                begin
                    // Pad sits as reset between steps; wait on the table read
                    settle <= settle + 4'h1;
                    if (settle == `SRPBM_SETTLE_CYC)
                    begin
                        settle <= 4'h0;
                        pad_fn <= step_fn;
                        state  <= `SRPBM_ST_STEP;
                    end
                end
                `SRPBM_ST_RUN:
                begin
                    if (keep_uart_tx_in)
                    begin
                        pad_fn   <= `SRPBM_FN_UART_TX;
                        dis_flag <= 1'b1;
                    end
                    else if (flash_req_in)
                        state <= `SRPBM_ST_FL_DIS;
                    if (reset_reenable_in)
                    begin
                        pad_fn   <= `SRPBM_FN_RESET;
                        dis_flag <= 1'b0;
                    end
                end
                `SRPBM_ST_FL_DIS:
                begin
                    dis_flag <= 1'b1;
                    state    <= `SRPBM_ST_FL_SEL;
                end
                `SRPBM_ST_FL_SEL:
                begin
                    pad_fn <= `SRPBM_FN_SPI_DO;
                    state  <= `SRPBM_ST_FL_ACC;
                end
                `SRPBM_ST_FL_ACC:
                begin
                    if (flash_done_in)
                    begin
                        pad_fn <= `SRPBM_FN_RESET;
                        state  <= `SRPBM_ST_FL_EN;
                    end
                end
                `SRPBM_ST_FL_EN:
                begin
                    // Flag drops four cycles after the pad is back, avoiding a pulse
                    settle <= settle + 4'h1;
                    if (settle == `SRPBM_SETTLE_CYC)
                    begin
                        settle   <= 4'h0;
                        dis_flag <= 1'b0;
                        state    <= `SRPBM_ST_RUN;
                    end
                end
                default:
                    state <= `SRPBM_ST_PORWAIT;
            endcase
        end
    end

    // ----------------------------------------
    // Reset gating and pad drive
    // ----------------------------------------
    wire pad_is_reset = (pad_fn == `SRPBM_FN_RESET);
    wire gpio_hit     = gpio_por_enable_in & (gpio_level == gpio_por_polarity_in);
    // Only trust the pad once it has sat as reset long enough for stale data to clear
    wire settled      = (state == `SRPBM_ST_RUN) |
                        ((state == `SRPBM_ST_GAP) & (settle != 4'h0));

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            shared_reset_pad_out        <= 1'b0;
            shared_reset_pad_oe_out     <= 1'b0;
            boot_step_out               <= 3'h0;
            uart_probe_out              <= 1'b0;
            flash_grant_out             <= 1'b0;
            hard_reset_disable_flag_out <= 1'b0;
            hard_reset_out              <= 1'b0;
            por_reset_out               <= 1'b0;
            boot_done_out               <= 1'b0;
        end
        else
        begin
            hard_reset_out <= pad_is_reset & settled & ~dis_flag
                              & pad_level;
            por_reset_out  <= gpio_hit;
            shared_reset_pad_oe_out <= (pad_fn == `SRPBM_FN_UART_TX) |
                                       (pad_fn == `SRPBM_FN_SPI_DO);
            case (pad_fn)
                `SRPBM_FN_UART_TX: shared_reset_pad_out <= uart_tx_data_in;
                `SRPBM_FN_SPI_DO:  shared_reset_pad_out <= spi_do_data_in;
                default:           shared_reset_pad_out <= 1'b0;
            endcase
            boot_step_out   <= (state == `SRPBM_ST_STEP) ? step : 3'h0;
            uart_probe_out  <= (state == `SRPBM_ST_STEP) &
                               (step == `SRPBM_STEP_UART2) & rx_level;
            flash_grant_out <= (state == `SRPBM_ST_FL_ACC);
            hard_reset_disable_flag_out <= dis_flag;
            boot_done_out   <= (state == `SRPBM_ST_RUN) | (state[2] == 1'b1);
        end
    end

endmodule // srpbm_top

/* logic/srpbm_defines.vh */
// Constants for the shared reset pad boot mux.
// Assumes inclusion by srpbm_top.v and srpbm_step_mem.v only.
`ifndef SRPBM_DEFINES_VH
`define SRPBM_DEFINES_VH

// ----------------------------------------
// Boot steps
// ----------------------------------------
`define SRPBM_STEP_W        3
`define SRPBM_STEP_SPI_MST  3'h1
`define SRPBM_STEP_UART1A   3'h2
`define SRPBM_STEP_UART1B   3'h3
`define SRPBM_STEP_UART2    3'h4
`define SRPBM_STEP_SPI_SLV  3'h5
`define SRPBM_STEP_I2C      3'h6
`define SRPBM_STEP_LAST     3'h6

// ----------------------------------------
// Pad function select
// ----------------------------------------
`define SRPBM_FN_W          2
`define SRPBM_FN_RESET      2'h0
`define SRPBM_FN_SERIAL_IN  2'h1
`define SRPBM_FN_UART_TX    2'h2
`define SRPBM_FN_SPI_DO     2'h3

// ----------------------------------------
// Machine states
// ----------------------------------------
`define SRPBM_ST_W          3
`define SRPBM_ST_PORWAIT    3'h0
`define SRPBM_ST_STEP       3'h1
`define SRPBM_ST_GAP        3'h2
`define SRPBM_ST_RUN        3'h3
`define SRPBM_ST_FL_DIS     3'h4
`define SRPBM_ST_FL_SEL     3'h5
`define SRPBM_ST_FL_ACC     3'h6
`define SRPBM_ST_FL_EN      3'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define SRPBM_SETTLE_CYC    4'h3
`define SRPBM_STEP_TMO      16'h0fff

`endif

/* logic/srpbm_step_mem.v */
// Boot step table: pad function per step, registered read.
// Assumes a single clock and a synchronous active-low reset upstream.
`timescale 1ns/1ns
`include "srpbm_defines.vh"

module srpbm_step_mem
(
    input  wire                     clk_in,
    input  wire [`SRPBM_STEP_W-1:0] addr_in,
    output reg  [`SRPBM_FN_W-1:0]   fn_out
);

    // Pad use per step; steps that leave the pad alone keep it as reset
    always @(posedge clk_in)
    begin
        case (addr_in)
            `SRPBM_STEP_SPI_MST: fn_out <= `SRPBM_FN_SPI_DO;
            `SRPBM_STEP_UART2:   fn_out <= `SRPBM_FN_UART_TX;
            `SRPBM_STEP_SPI_SLV: fn_out <= `SRPBM_FN_SERIAL_IN;
            default:             fn_out <= `SRPBM_FN_RESET;
        endcase
    end

endmodule // srpbm_step_mem

/* verification/srpbm_props.sv */
// Port-level assertions for the shared reset pad boot mux.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ns
module srpbm_props
(
    input wire       clk_in,
    input wire       rst_n_in,
    input wire       shared_reset_pad_in,
    input wire       reset_reenable_in,
    input wire       shared_reset_pad_oe_out,
    input wire [2:0] boot_step_out,
    input wire       flash_grant_out,
    input wire       hard_reset_disable_flag_out,
    input wire       hard_reset_out,
    input wire       boot_done_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    step_gap_a: assert property (
        boot_step_out != 3'h0 && $past(boot_step_out) != 3'h0
        |-> boot_step_out == $past(boot_step_out) && boot_step_out <= 3'h6)
        else $error("boot step changed without a gap");
    step_mute_a: assert property ((boot_step_out != 3'h0) [*6]
        |=> !$rose(hard_reset_out)) else $error("reset rose during a boot step");
    flag_mute_a: assert property (hard_reset_disable_flag_out [*6]
        |=> !$rose(hard_reset_out)) else $error("reset rose with flag set");
    grant_window_a: assert property (flash_grant_out
        |-> hard_reset_disable_flag_out && shared_reset_pad_oe_out)
        else $error("flash window without flag or drive");
    grant_order_a: assert property ($rose(flash_grant_out)
        |-> $past(hard_reset_disable_flag_out)) else $error("flash before flag");
    flag_clear_a: assert property ($fell(flash_grant_out)
        |-> ##[1:8] !hard_reset_disable_flag_out) else $error("flag stuck after flash");
    reset_cause_a: assert property ($rose(hard_reset_out) |->
        $past(shared_reset_pad_in, 4) || $past(shared_reset_pad_in, 5)
        || $past(shared_reset_pad_in, 6)) else $error("reset without pad high");
    reenable_a: assert property (
        reset_reenable_in && hard_reset_disable_flag_out && boot_done_out && !flash_grant_out
        |-> ##[1:4] !hard_reset_disable_flag_out) else $error("re-enable ignored");
    boot_release_a: assert property ($rose(boot_done_out)
        |-> ##[0:6] !shared_reset_pad_oe_out) else $error("pad not returned to reset");
endmodule // srpbm_props

bind srpbm_top srpbm_props i_srpbm_props (.clk_in, .rst_n_in, .shared_reset_pad_in,
    .reset_reenable_in, .shared_reset_pad_oe_out, .boot_step_out, .flash_grant_out,
    .hard_reset_disable_flag_out, .hard_reset_out, .boot_done_out);

/* verification/srpbm_far_end.sv */
// Far-end host model on the shared pad and its receive neighbour.
// Assumes the pad has a pull-down and only this model or the design drives it.
`timescale 1ns/1ns
module srpbm_far_end
(
    input  wire pad_oe_in,
    input  wire pad_drv_in,
    input  wire hold_high_in,
    output wire pad_level_out,
    output wire rx_level_out
);
    // Host never fights the device; pull-down wins when idle
    assign pad_level_out = pad_oe_in ? pad_drv_in : hold_high_in;
    // Host transmit line idles high, which the probe looks for
    assign rx_level_out  = 1'b1;
endmodule // srpbm_far_end

/* verification/tb_shared_reset_pin_boot_mux.sv */
// Self-checking bench for the shared reset pad boot mux.
// Assumes the far-end model resolves the shared pad level.
`timescale 1ns/1ns
module tb_shared_reset_pin_boot_mux;
    logic       clk_in = 1'b0;
    logic       rst_n = 1'b0;
    logic       gpio = 1'b0, gpio_en = 1'b0, sdone = 1'b0, found = 1'b0;
    logic       keep = 1'b0, tx_d = 1'b0, spi_d = 1'b0, freq = 1'b0;
    logic       fdone = 1'b0, reen = 1'b0, hold = 1'b0, gpio_pol = 1'b1;
    logic       pad_out, pad_oe, probe, grant, flag, hrst, por, done, pad_lvl, rx_lvl;
    logic [2:0] step;
    int         n_errors = 0;
    int         num_checks = 0;

    always #20 clk_in = ~clk_in;

    srpbm_far_end i_srpbm_far_end (.pad_oe_in(pad_oe), .pad_drv_in(pad_out),
        .hold_high_in(hold), .pad_level_out(pad_lvl), .rx_level_out(rx_lvl));
    srpbm_top i_srpbm_top (.clk_in(clk_in), .rst_n_in(rst_n), .shared_reset_pad_in(pad_lvl),
        .boot_uart_rx_pad_in(rx_lvl), .gpio_por_pad_in(gpio), .gpio_por_enable_in(gpio_en),
        .gpio_por_polarity_in(gpio_pol), .step_done_in(sdone), .boot_found_in(found),
        .keep_uart_tx_in(keep), .uart_tx_data_in(tx_d), .spi_do_data_in(spi_d),
        .flash_req_in(freq), .flash_done_in(fdone), .reset_reenable_in(reen),
        .shared_reset_pad_out(pad_out), .shared_reset_pad_oe_out(pad_oe),
        .boot_step_out(step), .uart_probe_out(probe), .flash_grant_out(grant),
        .hard_reset_disable_flag_out(flag), .hard_reset_out(hrst),
        .por_reset_out(por), .boot_done_out(done));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    task automatic t_boot;
        int i;
        logic [2:0] e;
        // One lap and four steps: the sequence must wrap, host found on the second UART step
        for (int k = 0; k < 10; k++)
        begin
            e = 3'(k % 6 + 1);
            for (i = 0; i < 40 && step === 3'h0; i++) tick(1);
            tick(2);
            chk("step", e, step);
            tx_d = (e == 3'h4);
            hold = (e == 3'h5);
            tick(6);
            chk("pad_use", (e == 3'h4) ? 3'h7 : {1'b0, e == 3'h1, 1'b0},
                {probe, pad_oe, pad_out});
            chk("no_rst", 3'h0, {2'b0, hrst});
            hold = 1'b0;
            tick(6);
            found = (k == 9);
            sdone = (k != 9);
            tick(1);
            found = 1'b0;
            sdone = 1'b0;
            tx_d = 1'b0;
            for (i = 0; i < 20 && step !== 3'h0; i++) tick(1);
            tick(2);
            chk("gap_quiet", 3'h0, {2'b0, hrst});
        end
        tick(8);
        chk("booted", 3'h2, {1'b0, done, pad_oe});
        $display("test boot finished");
    endtask
    task automatic t_flash;
        int i;
        spi_d = 1'b1;
        freq = 1'b1;
        tick(1);
        freq = 1'b0;
        for (i = 0; i < 20 && grant !== 1'b1; i++) tick(1);
        chk("fl_setup", 3'h3, {1'b0, flag, pad_oe});
        tick(8);
        chk("fl_mute", 3'h2, {1'b0, pad_out, hrst});
        fdone = 1'b1;
        tick(1);
        fdone = 1'b0;
        tick(8);
        chk("fl_end", 3'h0, {grant, flag, pad_oe});
        spi_d = 1'b0;
        $display("test flash finished");
    endtask
    task automatic t_keep;
        tx_d = 1'b1;
        keep = 1'b1;
        tick(1);
        keep = 1'b0;
        tick(10);
        chk("keep_tx", 3'h6, {flag, pad_oe, hrst});
        tx_d = 1'b0;
        reen = 1'b1;
        tick(1);
        reen = 1'b0;
        tick(6);
        chk("reenable", 3'h0, {1'b0, flag, pad_oe});
        $display("test keep finished");
    endtask
    task automatic t_pad;
        hold = 1'b1;
        tick(10);
        chk("pad_high", 3'h1, {2'b0, hrst});
        hold = 1'b0;
        tick(10);
        chk("pad_low", 3'h0, {2'b0, hrst});
        gpio_en = 1'b1;
        gpio = 1'b1;
        tick(10);
        chk("gpio_por", 3'h1, {2'b0, por});
        gpio_pol = 1'b0;
        tick(2);
        chk("gpio_pol", 3'h0, {2'b0, por});
        gpio = 1'b0;
        tick(10);
        chk("gpio_low", 3'h1, {2'b0, por});
        $display("test pad finished");
    endtask
    task automatic t_rerun;
        int i;
        gpio_en = 1'b0;
        rst_n = 1'b0;
        tick(2);
        chk("rst_outs", 3'h0, {done, flag, hrst});
        chk("rst_pad", 3'h0, {grant, por, pad_oe});
        rst_n = 1'b1;
        tick(2);
        chk("rst_quiet", 3'h0, {done, flag, pad_oe});
        for (i = 0; i < 40 && step === 3'h0; i++) tick(1);
        chk("restart", 3'h1, step);
        $display("test rerun finished");
    endtask

    initial
    begin
        tick(10);
        rst_n = 1'b1;
        t_boot();
        t_flash();
        t_keep();
        t_pad();
        t_rerun();
        report_and_stop();
    end
    // Whole run needs well under 2000 cycles
    initial
    begin
        #200000;
        n_errors++;
        report_and_stop();
    end
endmodule // tb_shared_reset_pin_boot_mux
